// ### logic/socket_events_pkg.sv
// Package with register offsets, field positions and reset values for the socket event block.
package socket_events_pkg;
	localparam int unsigned addr_width = 8;
	localparam logic [7:0] change_events_offset = 8'h00;
	localparam logic [7:0] change_enables_offset = 8'h04;
	localparam logic [7:0] force_event_offset = 8'h0c;
	localparam int unsigned event_width = 4;
	localparam int unsigned card_status_bit = 0;
	localparam int unsigned detect_one_bit = 1;
	localparam int unsigned detect_two_bit = 2;
	localparam int unsigned power_cycle_bit = 3;
	localparam logic [3:0] events_reset = 4'h0;
	localparam logic [3:0] enables_reset = 4'h0;
	localparam logic [1:0] detect_enable_on = 2'h3;
	localparam logic [31:0] read_zero = 32'h0000_0000;

	typedef enum logic [1:0] {
		sig_edge = 2'b01,
		sig_level = 2'b10
	} signal_mode_t;
endpackage

// ### logic/socket_event_if.sv
// Interface carrying detected socket changes from the edge detector to the event latch.
interface socket_event_if;
	logic [3:0] change;

	modport source (output change);
	modport sink (input change);
endinterface

// ### logic/socket_change_detect.sv
// Synchronises the socket status inputs and reports changes of the four event inputs as one-cycle pulses; for a CardBus card only card status rises.
module socket_change_detect
	import socket_events_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Socket status, asynchronous to mclk
	input wire logic power_cycle_state,
	input wire logic detect_one_pin,
	input wire logic detect_two_pin,
	input wire logic card_status_change_pin,
	input wire logic cardbus_card,
	// Detected changes
	socket_event_if.source ev
);
	logic [3:0] raw;
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] last_reg;
	logic [3:0] toggled;
	logic cb_sync1_reg;
	logic cb_sync2_reg;
	logic cst_rise;

	assign raw = {power_cycle_state, detect_two_pin, detect_one_pin, card_status_change_pin};

	always_ff @(posedge mclk) begin
		if (srst) begin
			sync1_reg <= events_reset;
			sync2_reg <= events_reset;
			last_reg <= events_reset;
			cb_sync1_reg <= 1'b0;
			cb_sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= raw;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
			cb_sync1_reg <= cardbus_card;
			cb_sync2_reg <= cb_sync1_reg;
		end
	end

	// Only that a level moved is reported, never its new value.
	assign toggled = sync2_reg ^ last_reg;
	assign cst_rise = sync2_reg[card_status_bit] & ~last_reg[card_status_bit];
	// Last-state register resets to zero, so a pin still active after reset
	// shows as a fresh change and sets its event again.
	assign ev.change = {toggled[power_cycle_bit], toggled[detect_two_bit],
		toggled[detect_one_bit],
		cb_sync2_reg ? cst_rise : toggled[card_status_bit]};
endmodule // socket_change_detect

// ### logic/socket_change_events.sv
// Socket status-change event and enable registers with the status-change interrupt.
module socket_change_events
	import socket_events_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Register access
	input wire logic [addr_width-1:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// Socket status
	input wire logic power_cycle_state,
	input wire logic detect_one_pin,
	input wire logic detect_two_pin,
	input wire logic card_status_change_pin,
	input wire logic cardbus_card,
	// Interrupt signalling
	input wire logic status_change_signal_select,
	output logic status_change_interrupt
);
	socket_event_if ev ();

	logic [3:0] events_reg;
	logic [3:0] events_next;
	logic [3:0] enables_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic irq_reg;
	logic irq_next;
	logic req_prev_reg;
	logic level_sel_reg;
	signal_mode_t mode;
	logic [3:0] clear_bits;
	logic [3:0] force_bits;
	logic [3:0] gated;
	logic request;
	logic wr_events;
	logic wr_enables;
	logic wr_force;

	function automatic logic hit(input logic [addr_width-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	socket_change_detect detect (
		.mclk(mclk),
		.srst(srst),
		.power_cycle_state(power_cycle_state),
		.detect_one_pin(detect_one_pin),
		.detect_two_pin(detect_two_pin),
		.card_status_change_pin(card_status_change_pin),
		.cardbus_card(cardbus_card),
		.ev(ev)
	);

	assign wr_events = reg_write & hit(reg_addr, change_events_offset);
	assign wr_enables = reg_write & hit(reg_addr, change_enables_offset);
	assign wr_force = reg_write & hit(reg_addr, force_event_offset);
	assign clear_bits = wr_events ? reg_wdata[event_width-1:0] : 4'h0;
	assign force_bits = wr_force ? reg_wdata[event_width-1:0] : 4'h0;

	// A change in the same cycle as its clear wins, so no event is lost.
	assign events_next = (events_reg & ~clear_bits) | ev.change | force_bits;

	// The two detect enable bits must both be set; 01 and 10 act as off.
	assign gated[power_cycle_bit] = events_reg[power_cycle_bit]
		& enables_reg[power_cycle_bit];
	assign gated[detect_two_bit] = events_reg[detect_two_bit]
		& (enables_reg[detect_two_bit:detect_one_bit] == detect_enable_on);
	assign gated[detect_one_bit] = events_reg[detect_one_bit]
		& (enables_reg[detect_two_bit:detect_one_bit] == detect_enable_on);
	assign gated[card_status_bit] = events_reg[card_status_bit]
		& enables_reg[card_status_bit];
	// Request follows enables, so a stale event fires once unmasked.
	assign request = |gated;

	assign mode = level_sel_reg ? sig_level : sig_edge;

	always_comb begin
		case (mode)
			sig_level: irq_next = request;
			sig_edge: irq_next = request & ~req_prev_reg;
			default: irq_next = 1'b0;
		endcase
	end

	assign rdata_next = !reg_read ? rdata_reg
		: hit(reg_addr, change_events_offset) ? {28'h0, events_reg}
		: hit(reg_addr, change_enables_offset) ? {28'h0, enables_reg}
		: read_zero;

	always_ff @(posedge mclk) begin
		if (srst) begin
			events_reg <= events_reset;
			enables_reg <= enables_reset;
			rdata_reg <= read_zero;
			irq_reg <= 1'b0;
			req_prev_reg <= 1'b0;
			level_sel_reg <= 1'b0;
		end else begin
			events_reg <= events_next;
			if (wr_enables) begin
				enables_reg <= reg_wdata[event_width-1:0];
			end
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
			req_prev_reg <= request;
			level_sel_reg <= status_change_signal_select;
		end
	end

	assign reg_rdata = rdata_reg;
	assign status_change_interrupt = irq_reg;
endmodule // socket_change_events

// ### dv/socket_change_events_monitor.sv
// Checker bound to the socket event block's ports.
module socket_change_events_monitor
	import socket_events_pkg::*;
(
	// Clock, reset and register access
	input wire logic mclk,
	input wire logic srst,
	input wire logic [addr_width-1:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// Interrupt
	input wire logic status_change_signal_select,
	input wire logic status_change_interrupt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_hi; reg_rdata[31:4] == 28'h0; endproperty
	a_hi: assert property (p_hi) else $error("rdata hi");
	property p_rd0; disable iff (1'b0) srst |=> reg_rdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("rdata rst");
	property p_irq0; disable iff (1'b0) srst |=> !status_change_interrupt; endproperty
	a_irq0: assert property (p_irq0) else $error("irq rst");
	property p_unmap; reg_read && reg_addr != change_events_offset &&
		reg_addr != change_enables_offset |=> reg_rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_rw; reg_write && reg_addr == change_enables_offset ##1 reg_read &&
		reg_addr == change_enables_offset |=> reg_rdata == ($past(reg_wdata, 2) & 32'hf); endproperty
	a_rw: assert property (p_rw) else $error("enables");
	property p_force; reg_write && reg_addr == force_event_offset ##1 reg_read &&
		reg_addr == change_events_offset |=>
		(reg_rdata & $past(reg_wdata, 2) & 32'hf) == ($past(reg_wdata, 2) & 32'hf); endproperty
	a_force: assert property (p_force) else $error("force");
	property p_pulse; status_change_interrupt && !status_change_signal_select &&
		!$past(status_change_signal_select) && !$past(status_change_signal_select, 2)
		|=> !status_change_interrupt; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_off; reg_write && reg_addr == change_enables_offset && reg_wdata[3:0] == 4'h0 &&
		status_change_signal_select && $past(status_change_signal_select)
		|=> ##1 !status_change_interrupt; endproperty
	a_off: assert property (p_off) else $error("masked");
endmodule // socket_change_events_monitor

bind socket_change_events socket_change_events_monitor i_mon (.*);

// ### dv/card_model.sv
// Card that flips its status pins, in event bit order, when the bench asks.
module card_model (
	// Clock and requests
	input wire logic mclk,
	input wire logic [3:0] flip,
	// Status pins
	output logic [3:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pins = 4'h0;
	always @(posedge mclk) begin
		pins <= pins ^ flip;
	end
endmodule // card_model

// ### dv/socket_change_events_test.sv
// Bench for the socket status-change event block.
module socket_change_events_test
	import socket_events_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, cardbus_card = 1'b0;
	logic status_change_signal_select = 1'b1, status_change_interrupt;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [3:0] flip = 4'h0, pins;
	int err_total = 0, n_checks = 0;
	always #25 mclk = ~mclk;
	card_model i_card (.mclk, .flip, .pins);
	socket_change_events i_dut (.*, .power_cycle_state(pins[3]), .detect_two_pin(pins[2]),
		.detect_one_pin(pins[1]), .card_status_change_pin(pins[0]));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// Strobes stay up until the next access or idle, so back-to-back accesses need no gap.
	task op(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_write <= w;
		reg_read <= !w;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task idle(input int n);
		repeat (n) begin
			@(posedge mclk);
			reg_write <= 1'b0;
			reg_read <= 1'b0;
			flip <= 4'h0;
		end
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		op(1'b0, a, 32'h0);
		idle(1);
		chk("rdata", e, reg_rdata);
	endtask
	// Pins pass two sync flops and an edge stage, so five idle cycles cover it.
	task tog(input logic [3:0] m);
		@(posedge mclk);
		flip <= m;
		idle(5);
	endtask
	task t_pins;
		for (int b = 0; b < 4; b++) begin
			for (int k = 0; k < 2; k++) begin
				tog(4'h1 << b);
				rd(8'h00, 32'h1 << b);
				op(1'b1, 8'h00, 32'h0);
				rd(8'h00, 32'h1 << b);
				op(1'b1, 8'h00, 32'h1 << b);
				rd(8'h00, 32'h0);
			end
		end
	endtask
	task t_cardbus;
		@(posedge mclk);
		cardbus_card <= 1'b1;
		for (int k = 1; k >= 0; k--) begin
			tog(4'h1);
			rd(8'h00, k);
			op(1'b1, 8'h00, 32'h1);
		end
		idle(1);
	endtask
	task t_irq;
		logic [3:0] m;
		int n;
		op(1'b1, 8'h00, 32'hf);
		op(1'b1, 8'h04, 32'hffff_ffff);
		rd(8'h04, 32'hf);
		for (int b = 0; b < 4; b++) begin
			m = b == 0 ? 4'h1 : b == 3 ? 4'h8 : 4'h6;
			op(1'b1, 8'h04, {28'h0, ~m});
			op(1'b1, 8'h0c, 32'h1 << b);
			rd(8'h00, 32'h1 << b);
			chk("irq", 32'h0, {31'h0, status_change_interrupt});
			op(1'b1, 8'h04, {28'h0, m});
			idle(3);
			chk("irq", 32'h1, {31'h0, status_change_interrupt});
			op(1'b1, 8'h00, 32'h1 << b);
			op(1'b1, 8'h04, 32'h0);
			idle(3);
			chk("irq", 32'h0, {31'h0, status_change_interrupt});
		end
		@(posedge mclk);
		status_change_signal_select <= 1'b0;
		op(1'b1, 8'h04, 32'h1);
		op(1'b1, 8'h0c, 32'h1);
		idle(1);
		n = 0;
		repeat (6) begin
			@(negedge mclk);
			n += status_change_interrupt;
		end
		chk("pulses", 32'h1, n);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h0c, 32'h0);
		t_pins;
		t_cardbus;
		t_irq;
		end_sim;
	end
	initial begin
		#100000;
		err_total++;
		end_sim;
	end
endmodule // socket_change_events_test
